// ---- motor_ctrl_regs.svh ----
// offsets, field positions, reset values and timing counts of the stop and contact-hold block
`ifndef MOTOR_CTRL_REGS_SVH
`define MOTOR_CTRL_REGS_SVH
// register word offsets (byte address = 4 x offset)
`define OFF_STOP_METHOD 4'h0
`define OFF_LOW_SPEED 4'h1
`define OFF_STALL 4'h2
`define OFF_CONTACT 4'h3
`define OFF_CARRIER 4'h4
`define OFF_MODE 4'h5
`define OFF_STATUS 4'h6
// mode register field positions
`define MODE_PANEL_BIT 0
`define MODE_COMBINED_BIT 1
`define MODE_PROCESS_BIT 2
`define MODE_REMOTE_BIT 3
`define MODE_AUTO_ACC_BIT 4
`define MODE_VECTOR_BIT 5
// reset values
`define RST_STOP_METHOD 14'd9999
`define RST_LOW_SPEED 9'd10
`define RST_STALL2 14'd9999
`define RST_STALL1 8'd150
`define RST_EXCITE 14'd9999
`define RST_CARRIER2 14'd9999
`define RST_CARRIER1 4'h1
`define RST_START_FREQ 9'd1
// stop method codes and limits
`define SM_RAMP 14'd9999
`define SM_RAMP_DIR 14'd8888
`define SM_COAST_MAX 14'd100
`define SM_DIR_BASE 14'd1000
`define SM_DIR_MAX 14'd1100
`define NO_SETTING 14'd9999
`define CONTACT_FREQ_MAX 9'd30
`define CONTACT_CARRIER_FREQ 9'd3
// timing: one second at 10 MHz
`define CLK_HZ 10000000
`define SECOND_CYCLES (`CLK_HZ / 1)
`endif

// ---- motor_ctrl_pkg.sv ----
// types shared by the stop and contact-hold block
package motor_ctrl_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_RAMP, ST_COAST_WAIT} drive_state_e;
    typedef logic [13:0] setting_t;
endpackage

// ---- sec_tick_if.sv ----
// carrier between the control core and its one-second divider
`timescale 1ns/10ps
interface sec_tick_if;
    logic clear;
    logic tick;
    modport owner (output clear, input tick);
    modport divider (input clear, output tick);
endinterface

// ---- sec_divider.sv ----
// one-second enable pulse divider, restartable
`timescale 1ns/10ps
`include "motor_ctrl_regs.svh"
module sec_divider #(
    parameter int unsigned CYCLES = `SECOND_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // tick carrier
    sec_tick_if.divider tick_bus
);
    logic [31:0] count_reg;
    // count up, pulse at the end; clear lets a countdown start on a whole second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_reg <= 32'h0;
            tick_bus.tick <= 1'b0;
        end else if (tick_bus.clear || count_reg == CYCLES - 1) begin
            count_reg <= 32'h0;
            tick_bus.tick <= !tick_bus.clear;
        end else begin
            count_reg <= count_reg + 32'h1;
            tick_bus.tick <= 1'b0;
        end
    end
endmodule

// ---- motor_stop_contact.sv ----
// stop method and contact-hold control core with Avalon-MM registers
// ============================================================
`timescale 1ns/10ps
`include "motor_ctrl_regs.svh"
module motor_stop_contact #(
    parameter int unsigned SECOND_CYCLES = `SECOND_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // avalon-mm slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // run inputs
    input wire logic i_forward_or_start_input,
    input wire logic i_reverse_or_direction_input,
    input wire logic i_low_speed_select_input,
    input wire logic i_second_function_select_input,
    input wire logic i_inching_mode_input,
    // special stop requests
    input wire logic i_power_fail_stop,
    input wire logic i_panel_stop,
    input wire logic i_comm_error_stop,
    input wire logic i_network_emergency_stop,
    // ramp feedback: motor reached zero during deceleration
    input wire logic i_ramp_done,
    // drive outputs
    output logic o_output_enable,
    output logic o_running,
    output logic o_reverse,
    output logic o_ramp_down,
    output logic o_restart_from_start,
    output logic o_contact_hold,
    output logic [8:0] o_freq_command,
    output logic [13:0] o_stall_level,
    output logic [13:0] o_excitation_factor,
    output logic o_excitation_valid,
    output logic [3:0] o_carrier_setting
);
    import motor_ctrl_pkg::*;

    // ============================================================
    // registers
    setting_t stop_method_reg;
    logic [8:0] low_speed_reg;
    logic [8:0] normal_freq_reg;
    setting_t stall2_reg;
    logic [7:0] stall1_reg;
    logic contact_select_reg;
    setting_t excite_reg;
    setting_t carrier2_reg;
    logic [3:0] carrier1_reg;
    logic [8:0] start_freq_reg;
    logic [5:0] mode_reg;
    drive_state_e state_reg;
    logic [6:0] delay_reg;
    logic coasting_reg;
    logic low_seen_reg;
    logic second_seen_reg;
    sec_tick_if tick_bus ();

    sec_divider #(.CYCLES(SECOND_CYCLES)) u_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .tick_bus(tick_bus)
    );

    // decode of the stop method, used once by the start decode
    function automatic logic is_dir_mode(input setting_t sm);
        return (sm == `SM_RAMP_DIR) || (sm >= `SM_DIR_BASE && sm <= `SM_DIR_MAX);
    endfunction

    // ============================================================
    // bus slave: one wait cycle, so every access answers on the second edge
    // waitrequest is a flop of its own, so no gate sits between it and the bus
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
        end
    end
    wire wr_go = i_avs_write && !o_avs_waitrequest;

    // software writes; the mode register also carries start frequency, the low-speed register normal speed
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stop_method_reg <= `RST_STOP_METHOD;
            low_speed_reg <= `RST_LOW_SPEED;
            stall2_reg <= `RST_STALL2;
            stall1_reg <= `RST_STALL1;
            contact_select_reg <= 1'b0;
            excite_reg <= `RST_EXCITE;
            carrier2_reg <= `RST_CARRIER2;
            carrier1_reg <= `RST_CARRIER1;
            start_freq_reg <= `RST_START_FREQ;
            normal_freq_reg <= 9'h000;
            mode_reg <= 6'h00;
        end else if (wr_go) begin
            case (i_avs_address)
                `OFF_STOP_METHOD: stop_method_reg <= i_avs_writedata[13:0];
                `OFF_LOW_SPEED: begin
                    low_speed_reg <= i_avs_writedata[8:0];
                    normal_freq_reg <= i_avs_writedata[24:16];
                end
                `OFF_STALL: begin
                    stall2_reg <= i_avs_writedata[13:0];
                    stall1_reg <= i_avs_writedata[23:16];
                end
                `OFF_CONTACT: begin
                    contact_select_reg <= i_avs_writedata[16];
                    excite_reg <= i_avs_writedata[13:0];
                end
                `OFF_CARRIER: begin
                    carrier2_reg <= i_avs_writedata[13:0];
                    carrier1_reg <= i_avs_writedata[19:16];
                end
                `OFF_MODE: begin
                    mode_reg <= i_avs_writedata[5:0];
                    start_freq_reg <= i_avs_writedata[24:16];
                end
                default: begin
                end
            endcase
        end
    end

    // readback; unmapped addresses read zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_readdata <= 32'h0;
        end else begin
            case (i_avs_address)
                `OFF_STOP_METHOD: o_avs_readdata <= {18'h0, stop_method_reg};
                `OFF_LOW_SPEED: o_avs_readdata <= {7'h0, normal_freq_reg, 7'h0, low_speed_reg};
                `OFF_STALL: o_avs_readdata <= {8'h0, stall1_reg, 2'h0, stall2_reg};
                `OFF_CONTACT: o_avs_readdata <= {15'h0, contact_select_reg, 2'h0, excite_reg};
                `OFF_CARRIER: o_avs_readdata <= {12'h0, carrier1_reg, 2'h0, carrier2_reg};
                `OFF_MODE: o_avs_readdata <= {7'h0, start_freq_reg, 10'h0, mode_reg};
                `OFF_STATUS: o_avs_readdata <= {24'h0, 1'b0, delay_reg};
                default: o_avs_readdata <= 32'h0;
            endcase
            if (i_avs_address == `OFF_STATUS) begin
                o_avs_readdata[31:24] <= {3'h0, o_contact_hold, coasting_reg, o_running,
                    state_reg};
            end
        end
    end

    // ============================================================
    // start decode
    wire dir_mode = is_dir_mode(stop_method_reg);
    wire start_cmd = dir_mode ? i_forward_or_start_input
        : (i_forward_or_start_input ^ i_reverse_or_direction_input);
    wire want_reverse = dir_mode ? i_reverse_or_direction_input
        : i_reverse_or_direction_input;
    wire special_stop = i_power_fail_stop || i_panel_stop || i_comm_error_stop
        || i_network_emergency_stop;
    wire ramp_method = (stop_method_reg == `SM_RAMP) || (stop_method_reg == `SM_RAMP_DIR)
        || special_stop;
    wire coast_ok = stop_method_reg <= `SM_COAST_MAX
        || (stop_method_reg >= `SM_DIR_BASE && stop_method_reg <= `SM_DIR_MAX);
    wire [13:0] delay_full = (stop_method_reg >= `SM_DIR_BASE)
        ? stop_method_reg - `SM_DIR_BASE : stop_method_reg;
    assign tick_bus.clear = (state_reg == ST_RUN) && !start_cmd;

    // stop sequencing; special stops force the ramp path
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= ST_IDLE;
            delay_reg <= 7'h00;
        end else begin
            case (state_reg)
                ST_IDLE: if (start_cmd && !special_stop) state_reg <= ST_RUN;
                ST_RUN: begin
                    if (!start_cmd || special_stop) begin
                        if (ramp_method || !coast_ok) begin
                            state_reg <= ST_RAMP;
                        end else if (delay_full == 14'h0) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            state_reg <= ST_COAST_WAIT;
                            delay_reg <= delay_full[6:0];
                        end
                    end
                end
                ST_RAMP: begin
                    if (start_cmd && !special_stop) state_reg <= ST_RUN;
                    else if (i_ramp_done) state_reg <= ST_IDLE;
                end
                ST_COAST_WAIT: begin
                    if (special_stop) begin
                        state_reg <= ST_RAMP;
                    end else if (start_cmd) begin
                        state_reg <= ST_RUN;
                    end else if (tick_bus.tick) begin
                        if (delay_reg == 7'h1) state_reg <= ST_IDLE;
                        delay_reg <= delay_reg - 7'h1;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // coast tracking: set at shutoff, cleared by the restart it causes
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            coasting_reg <= 1'b0;
            o_restart_from_start <= 1'b0;
        end else begin
            o_restart_from_start <= 1'b0;
            if (state_reg == ST_IDLE && start_cmd && !special_stop && coasting_reg) begin
                o_restart_from_start <= 1'b1;
                coasting_reg <= 1'b0;
            end else if (state_reg != ST_IDLE && state_reg != ST_RAMP) begin
                coasting_reg <= coasting_reg;
            end
            if (state_reg == ST_RUN && (!start_cmd) && !ramp_method && coast_ok
                && delay_full == 14'h0) begin
                coasting_reg <= 1'b1;
            end
            if (state_reg == ST_COAST_WAIT && !special_stop && !start_cmd && tick_bus.tick
                && delay_reg == 7'h1) begin
                coasting_reg <= 1'b1;
            end
        end
    end

    // ============================================================
    // contact hold gate: both selects must be high in the same cycle, in either order of arrival
    wire contact_blocked = mode_reg[`MODE_PANEL_BIT] || i_inching_mode_input
        || mode_reg[`MODE_COMBINED_BIT] || mode_reg[`MODE_PROCESS_BIT]
        || mode_reg[`MODE_REMOTE_BIT] || mode_reg[`MODE_AUTO_ACC_BIT];
    wire contact_on = contact_select_reg && !contact_blocked
        && i_low_speed_select_input && i_second_function_select_input;
    wire [8:0] contact_freq = (low_speed_reg > `CONTACT_FREQ_MAX)
        ? `CONTACT_FREQ_MAX : low_speed_reg;
    wire [8:0] run_freq = contact_on ? contact_freq : normal_freq_reg;

    // drive outputs, all registered
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_output_enable <= 1'b0;
            o_running <= 1'b0;
            o_reverse <= 1'b0;
            o_ramp_down <= 1'b0;
            o_contact_hold <= 1'b0;
            o_freq_command <= 9'h000;
        end else begin
            // output stays on while waiting for the coast delay
            o_output_enable <= state_reg != ST_IDLE;
            o_running <= state_reg != ST_IDLE;
            if (state_reg == ST_RUN) o_reverse <= want_reverse;
            o_ramp_down <= state_reg == ST_RAMP;
            o_contact_hold <= contact_on;
            o_freq_command <= (o_restart_from_start) ? start_freq_reg : run_freq;
        end
    end

    // contact-hold tuning outputs
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_stall_level <= 14'h0;
            o_excitation_factor <= 14'h0;
            o_excitation_valid <= 1'b0;
            o_carrier_setting <= `RST_CARRIER1;
        end else begin
            o_stall_level <= (contact_on && stall2_reg != `NO_SETTING)
                ? stall2_reg : {6'h0, stall1_reg};
            o_excitation_valid <= contact_on && mode_reg[`MODE_VECTOR_BIT]
                && excite_reg != `NO_SETTING;
            o_excitation_factor <= excite_reg == `NO_SETTING ? 14'h0 : excite_reg;
            o_carrier_setting <= (contact_on && carrier2_reg != `NO_SETTING
                && run_freq <= `CONTACT_CARRIER_FREQ)
                ? carrier2_reg[3:0] : carrier1_reg;
        end
    end
endmodule

// ---- motor_stop_contact_assertions.sv ----
// concurrent checks on the ports of the stop and contact-hold block
`timescale 1ns/10ps
module motor_stop_contact_assertions (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // bus handshake
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    // run side
    input wire logic i_low_speed_select_input,
    input wire logic i_second_function_select_input,
    input wire logic i_inching_mode_input,
    input wire logic i_power_fail_stop,
    input wire logic i_panel_stop,
    input wire logic i_comm_error_stop,
    input wire logic i_network_emergency_stop,
    input wire logic i_ramp_done,
    // drive side
    input wire logic o_output_enable,
    input wire logic o_running,
    input wire logic o_ramp_down,
    input wire logic o_restart_from_start,
    input wire logic o_contact_hold,
    input wire logic [8:0] o_freq_command,
    input wire logic [13:0] o_stall_level
);
    logic stop_any;
    // ============================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // any special stop request counts alike
    assign stop_any = i_power_fail_stop | i_panel_stop | i_comm_error_stop
        | i_network_emergency_stop;
    bus_answer_a: assert property ($rose(i_avs_read || i_avs_write) |=> !o_avs_waitrequest)
        else $error("bus request not answered after one cycle");
    run_drop_a: assert property ($fell(o_output_enable) |-> $fell(o_running))
        else $error("running status outlived output shutoff");
    ramp_hold_a: assert property (o_ramp_down && !i_ramp_done |=> o_output_enable)
        else $error("output dropped during deceleration");
    stop_force_a: assert property ((stop_any && o_output_enable && !i_ramp_done) [*3]
        |-> o_ramp_down) else $error("special stop did not decelerate");
    // output enable is registered from the run state that the pulse's edge enters, so it follows one cycle later
    restart_pulse_a: assert property (o_restart_from_start |=> o_output_enable
        && !o_restart_from_start) else $error("restart pulse malformed");
    both_sel_a: assert property (!(i_low_speed_select_input
        && i_second_function_select_input) [*2] |=> !o_contact_hold)
        else $error("contact hold without both selects");
    inch_block_a: assert property (i_inching_mode_input [*2] |=> !o_contact_hold)
        else $error("contact hold during inching");
    freq_clamp_a: assert property (o_contact_hold ##1 o_contact_hold
        |-> o_freq_command <= 9'h01E) else $error("contact frequency above clamp");
    stall_pick_a: assert property (o_contact_hold ##1 o_contact_hold
        |-> o_stall_level != 14'h270F) else $error("stall level shows no-setting code");
endmodule

// ---- ext_controller.sv ----
// far-side controller model: run, direction and contact select inputs
`timescale 1ns/10ps
module ext_controller (
    // clock
    input wire logic i_clk,
    // bench commands
    input wire logic i_run,
    input wire logic i_dir,
    input wire logic i_split,
    input wire logic i_hold,
    input wire logic i_rl_first,
    // drive pins
    output logic o_fwd = 1'b0,
    output logic o_rev = 1'b0,
    output logic o_rl = 1'b0,
    output logic o_rt = 1'b0
);
    logic [1:0] gap_reg = 2'h0;
    // separate starts, or start plus direction level
    always @(posedge i_clk) begin
        o_fwd <= i_run && !(i_split && i_dir);
        o_rev <= i_split ? (i_run && i_dir) : i_dir;
    end
    // selects arrive apart in either order, then both are held high together once the gap count saturates at 3
    always @(posedge i_clk) begin
        gap_reg <= i_hold ? gap_reg + {1'b0, gap_reg != 2'h3} : 2'h0;
        o_rl <= i_hold && (i_rl_first || gap_reg == 2'h3);
        o_rt <= i_hold && (!i_rl_first || gap_reg == 2'h3);
    end
endmodule

// ---- motor_stop_contact_tb.sv ----
// self-checking bench for the stop and contact-hold block
`timescale 1ns/10ps
module motor_stop_contact_tb;
    localparam int unsigned SEC = 10;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [3:0] i_avs_address = 4'h0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic i_avs_read = 1'b0, i_avs_write = 1'b0, i_inching_mode_input = 1'b0, i_ramp_done = 1'b0;
    logic i_power_fail_stop = 1'b0, i_panel_stop = 1'b0, i_comm_error_stop = 1'b0;
    logic i_network_emergency_stop = 1'b0, run = 1'b0, dir = 1'b0, split = 1'b1, hold = 1'b0;
    logic i_forward_or_start_input, i_reverse_or_direction_input, seen;
    logic i_low_speed_select_input, i_second_function_select_input;
    logic [31:0] o_avs_readdata, got;
    logic o_avs_waitrequest, o_output_enable, o_running, o_reverse, o_ramp_down;
    logic o_restart_from_start, o_contact_hold, o_excitation_valid;
    logic [8:0] o_freq_command;
    logic [13:0] o_stall_level, o_excitation_factor;
    logic [3:0] o_carrier_setting;
    int bad_count = 0, n_checks = 0, cyc = 0, k, n;
    // reset rows: address, mask, expected
    logic [3:0] r_adr [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
    logic [31:0] r_msk [8] = '{32'h3FFF, 32'h1FF, 32'hFF3FFF, 32'h13FFF, 32'hF3FFF,
        32'h1FF0000, 32'h1F00007F, 32'hFFFFFFFF};
    logic [31:0] r_exp [8] = '{32'h270F, 32'hA, 32'h96270F, 32'h270F, 32'h1270F,
        32'h10000, 32'h0, 32'h0};
    // ============================================================
    // instances
    always #50 i_clk = ~i_clk;
    motor_stop_contact #(.SECOND_CYCLES(SEC)) u_dut (
        .i_clk, .i_rst_n, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
        .o_avs_readdata, .o_avs_waitrequest, .i_forward_or_start_input,
        .i_reverse_or_direction_input, .i_low_speed_select_input,
        .i_second_function_select_input, .i_inching_mode_input, .i_power_fail_stop,
        .i_panel_stop, .i_comm_error_stop, .i_network_emergency_stop, .i_ramp_done,
        .o_output_enable, .o_running, .o_reverse, .o_ramp_down, .o_restart_from_start,
        .o_contact_hold, .o_freq_command, .o_stall_level, .o_excitation_factor,
        .o_excitation_valid, .o_carrier_setting);
    ext_controller u_ext (.i_clk, .i_run(run), .i_dir(dir), .i_split(split), .i_hold(hold),
        .i_rl_first(1'b0), .o_fwd(i_forward_or_start_input),
        .o_rev(i_reverse_or_direction_input), .o_rl(i_low_speed_select_input),
        .o_rt(i_second_function_select_input));
    // ============================================================
    // tasks
    task automatic end_sim();
        if (bad_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic go(input int c);
        repeat (c) @(posedge i_clk);
    endtask
    // checks look at the falling edge, where registered outputs have settled
    task automatic peek(input int c);
        go(c);
        @(negedge i_clk);
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        logic lo;
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_read <= !w;
        i_avs_write <= w;
        // hold until waitrequest is seen low at a rising edge; read data taken there
        do begin
            @(posedge i_clk);
            lo = (o_avs_waitrequest === 1'b0);
            got = o_avs_readdata;
        end while (!lo);
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask
    // counts falling edges until the output shuts off, bounded
    task automatic wait_off();
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_output_enable !== 1'b0 && n < 3000);
    endtask
    task automatic coast(input logic [31:0] s, input logic sp, input logic d, input int t);
        bus(1'b1, 4'h0, s);
        split <= sp;
        dir <= d;
        run <= 1'b1;
        peek(6);
        chk(o_output_enable, 1'b1);
        chk(o_reverse, d);
        go(1);
        run <= 1'b0;
        wait_off();
        // the partner pin, three register stages and the falling-edge sampling add up to five cycles to the delay
        chk(n >= t * SEC && n <= t * SEC + 5, 1'b1);
        chk(o_running, 1'b0);
    endtask
    // ============================================================
    // sequence
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        go(16);
        i_rst_n <= 1'b1;
        for (k = 0; k < 8; k++) begin
            bus(1'b0, r_adr[k], 32'h0);
            chk(got & r_msk[k], r_exp[k]);
        end
        coast(32'h2, 1'b1, 1'b0, 2);
        coast(32'h0, 1'b1, 1'b1, 0);
        coast(32'h64, 1'b1, 1'b1, 100);
        coast(32'h3E9, 1'b0, 1'b1, 1);
        coast(32'h44C, 1'b0, 1'b0, 100);
        // start returns while the coast delay is still pending
        bus(1'b1, 4'h0, 32'h3);
        run <= 1'b1;
        go(6);
        run <= 1'b0;
        go(10);
        run <= 1'b1;
        peek(40);
        chk(o_output_enable, 1'b1);
        go(1);
        run <= 1'b0;
        wait_off();
        // start again once the output is off and the motor coasts
        go(1);
        run <= 1'b1;
        seen = 1'b0;
        got = 32'h0;
        repeat (6) begin
            peek(1);
            if (seen && got == 32'h0) got = {23'h0, o_freq_command};
            seen = seen | (o_restart_from_start === 1'b1);
        end
        chk(seen, 1'b1);
        chk(got, 32'h1);
        go(1);
        run <= 1'b0;
        wait_off();
        // ramp codes, then each special stop over a coast setting
        for (k = 0; k < 6; k++) begin
            bus(1'b1, 4'h0, k == 0 ? 32'h270F : (k == 1 ? 32'h22B8 : 32'h2));
            run <= 1'b1;
            go(6);
            run <= 1'b0;
            if (k > 1)
                {i_power_fail_stop, i_panel_stop, i_comm_error_stop,
                    i_network_emergency_stop} <= 4'h1 << (k - 2);
            peek(40);
            chk({o_ramp_down, o_output_enable}, 2'h3);
            go(1);
            i_ramp_done <= 1'b1;
            peek(3);
            chk(o_output_enable, 1'b0);
            go(1);
            i_ramp_done <= 1'b0;
            {i_power_fail_stop, i_panel_stop, i_comm_error_stop, i_network_emergency_stop} <= 4'h0;
        end
        // contact hold: vector control, clamp, stall, excitation, carrier
        bus(1'b1, 4'h5, 32'h10020);
        bus(1'b1, 4'h1, 32'h28);
        bus(1'b1, 4'h3, 32'h10096);
        run <= 1'b1;
        hold <= 1'b1;
        peek(12);
        chk({o_contact_hold, o_freq_command}, {1'b1, 9'h01E});
        chk(o_stall_level, 14'h0096);
        chk({o_excitation_valid, o_excitation_factor}, {1'b1, 14'h0096});
        chk(o_carrier_setting, 4'h1);
        bus(1'b1, 4'h1, 32'h2);
        bus(1'b1, 4'h4, 32'h10005);
        bus(1'b1, 4'h2, 32'h960064);
        peek(5);
        chk({o_freq_command, o_carrier_setting}, {9'h002, 4'h5});
        chk(o_stall_level, 14'h0064);
        // above 3 Hz the normal carrier comes back even in contact hold
        bus(1'b1, 4'h1, 32'h4);
        peek(5);
        chk({o_freq_command, o_carrier_setting}, {9'h004, 4'h1});
        go(1);
        i_inching_mode_input <= 1'b1;
        peek(5);
        chk(o_contact_hold, 1'b0);
        go(1);
        i_inching_mode_input <= 1'b0;
        for (k = 0; k < 5; k++) begin
            bus(1'b1, 4'h5, 32'h10020 | (32'h1 << k));
            peek(4);
            chk(o_contact_hold, 1'b0);
        end
        bus(1'b1, 4'h5, 32'h10020);
        bus(1'b1, 4'h3, 32'h1270F);
        peek(4);
        chk({o_contact_hold, o_excitation_valid}, 2'h2);
        bus(1'b1, 4'h3, 32'h0);
        peek(4);
        chk(o_contact_hold, 1'b0);
        // reset in mid-run
        go(1);
        hold <= 1'b0;
        i_rst_n <= 1'b0;
        peek(1);
        chk({o_output_enable, o_avs_waitrequest, o_carrier_setting}, 6'h11);
        go(2);
        run <= 1'b0;
        i_rst_n <= 1'b1;
        // the contact register must be back at its reset value after the release
        bus(1'b0, 4'h3, 32'h0);
        chk(got & 32'h13FFF, 32'h270F);
        go(4);
        end_sim();
    end
endmodule
bind motor_stop_contact motor_stop_contact_assertions u_chk (.i_clk, .i_rst_n, .i_avs_read,
    .i_avs_write, .o_avs_waitrequest, .i_low_speed_select_input,
    .i_second_function_select_input, .i_inching_mode_input, .i_power_fail_stop,
    .i_panel_stop, .i_comm_error_stop, .i_network_emergency_stop, .i_ramp_done,
    .o_output_enable, .o_running, .o_ramp_down, .o_restart_from_start, .o_contact_hold,
    .o_freq_command, .o_stall_level);
